// File: shared/irpc_cfg.svh
/*
 * Constants for the interrupt and reset pin control block: register offsets, field positions,
 * reset values and vector offsets.
 * Assumes byte addresses on an 8-bit register port with 32-bit data.
 */
`ifndef IRPC_CFG_SVH
`define IRPC_CFG_SVH

`define IRPC_ADDR_W 8
`define IRPC_DATA_W 32
`define IRPC_NUM_EXT 4
`define IRPC_HALF_EXT 2

`define IRPC_OFS_ENABLE_LO 8'h00
`define IRPC_OFS_ENABLE_HI 8'h04
`define IRPC_OFS_FLAG_LO 8'h08
`define IRPC_OFS_FLAG_HI 8'h0c
`define IRPC_OFS_STATUS_ONE 8'h10
`define IRPC_OFS_TIMER_SEL 8'h14
`define IRPC_OFS_VECPTR 8'h18
`define IRPC_OFS_HOST_CTRL 8'h1c
`define IRPC_OFS_STATE 8'h20

`define IRPC_BIT_GLOBAL_MASK 0
`define IRPC_BIT_WDT_SEL 0
`define IRPC_BIT_HOST_IRQ 0
`define IRPC_BIT_ST_RUN 0
`define IRPC_BIT_ST_NMI 1
`define IRPC_BIT_ST_OFF 2
`define IRPC_BIT_ST_HPE 3

`define IRPC_RST_GLOBAL_MASK 1'b1
`define IRPC_RST_WDT_SEL 1'b0
`define IRPC_RST_VECPTR 16'hffff
`define IRPC_RST_ENABLE 4'h0
`define IRPC_RST_HOST_IRQ 1'b0

`define IRPC_VEC_RESET 8'h00
`define IRPC_VEC_NMI 8'h08
`define IRPC_VEC_INT_BASE 8'h10

`endif

// File: shared/irpc_pkg.sv
/*
 * Types shared by the interrupt and reset pin control block.
 * Assumes irpc_cfg.svh for all numeric constants.
 */
package irpc_pkg;

    typedef enum logic [1:0] {
        IRPC_ST_HOLD = 2'b00,
        IRPC_ST_BOOT = 2'b01,
        IRPC_ST_RUN = 2'b11,
        IRPC_ST_ACK = 2'b10
    } irpc_state_type;

    typedef logic [3:0] irpc_src_type;

endpackage : irpc_pkg

// File: core/irpc_flag_bank.sv
/*
 * Edge latching flag bank for the active-low external interrupt inputs.
 * Assumes inputs synchronous to sys_clk; a new edge wins over a per-bit clear in the same cycle, clear_all wins over an edge.
 */
`timescale 1ns/1ns
`default_nettype none
`include "irpc_cfg.svh"

module irpc_flag_bank
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire irpc_pkg::irpc_src_type irq_n_in,
    input wire irpc_pkg::irpc_src_type clear,
    input wire logic clear_all,
    output irpc_pkg::irpc_src_type flags
);
    import irpc_pkg::*;

    irpc_src_type prev_ff;
    irpc_src_type nxt_prev;
    irpc_src_type flag_ff;
    irpc_src_type nxt_flag;

    genvar i;
    generate
        for (i = 0; i < `IRPC_NUM_EXT; i = i + 1)
        begin : g_src
            // Falling edge sets; set beats per-bit clear, clear_all beats set
            always_comb
            begin
                nxt_prev[i] = irq_n_in[i];
                nxt_flag[i] = flag_ff[i];
                if (clear_all)
                    nxt_flag[i] = 1'b0;
                else if (prev_ff[i] && !irq_n_in[i])
                    nxt_flag[i] = 1'b1;
                else if (clear[i])
                    nxt_flag[i] = 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            prev_ff <= 4'hf;
            flag_ff <= 4'h0;
        end
        else
        begin
            prev_ff <= nxt_prev;
            flag_ff <= nxt_flag;
        end
    end

    assign flags = flag_ff;

endmodule : irpc_flag_bank
`default_nettype wire

// File: core/irpc_top.sv
/*
 * Interrupt, reset and host interrupt pin control: external interrupt flags and enables,
 * global mask, shared non-maskable/watchdog pin, acknowledge, reset vector fetch,
 * host interrupt pin, host port enable and OFF-mode tri-stating.
 * Assumes all pin inputs synchronous to sys_clk; a simple register port with read data
 * one cycle after the read strobe; output enables are active low.
 */
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "irpc_cfg.svh"

module irpc_top
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [`IRPC_ADDR_W-1:0] reg_addr,
    input wire logic [`IRPC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`IRPC_DATA_W-1:0] reg_rdata,
    input wire irpc_pkg::irpc_src_type ext_irq_n_in,
    input wire logic device_reset_n_in,
    input wire logic nmi_watchdog_shared_pin_in,
    output logic nmi_watchdog_shared_pin_out,
    output logic nmi_watchdog_shared_pin_oe_n,
    input wire logic watchdog_out,
    output logic watchdog_pin_to_timer,
    output logic irq_acknowledge_out,
    output logic irq_acknowledge_oe_n,
    output logic host_irq_out,
    output logic host_irq_oe_n,
    input wire logic host_port_enable_in,
    output logic host_port_active,
    input wire logic test_reset_n_in,
    input wire logic emulation_pin_zero,
    input wire logic emulation_pin_one_off,
    output logic exec_run,
    output logic vector_fetch,
    output logic [23:0] vector_addr,
    output logic cpu_irq_out
);
    import irpc_pkg::*;

    // Register state
    irpc_src_type enable_ff;
    irpc_src_type nxt_enable;
    logic global_irq_mask_bit_ff;
    logic nxt_global_irq_mask_bit;
    logic wdt_sel_ff;
    logic nxt_wdt_sel;
    logic [15:0] vecptr_ff;
    logic [15:0] nxt_vecptr;
    logic host_irq_ff;
    logic nxt_host_irq;
    logic [`IRPC_DATA_W-1:0] rdata_ff;
    logic [`IRPC_DATA_W-1:0] nxt_rdata;

    // Sequencer state
    irpc_state_type state_ff;
    irpc_state_type nxt_state;
    logic nmi_prev_ff;
    logic nxt_nmi_prev;
    logic nmi_pend_ff;
    logic nxt_nmi_pend;
    logic fetch_ff;
    logic nxt_fetch;
    logic [23:0] vaddr_ff;
    logic [23:0] nxt_vaddr;

    // Pin state
    logic wdt_pin_ff;
    logic nxt_wdt_pin;
    logic wdt_oe_n_ff;
    logic nxt_wdt_oe_n;
    logic ack_ff;
    logic nxt_ack;
    logic ack_oe_n_ff;
    logic nxt_ack_oe_n;
    logic host_irq_out_ff;
    logic nxt_host_irq_out;
    logic host_irq_out_oe_n_ff;
    logic nxt_host_irq_out_oe_n;
    logic hpe_ff;
    logic nxt_hpe;

    // Shared combinational terms
    irpc_src_type flags;
    irpc_src_type flag_clear;
    irpc_src_type svc_clear;
    irpc_src_type ready;
    logic in_reset;
    logic off_mode;
    logic nmi_edge;
    logic svc_any;
    logic [1:0] svc_idx;
    logic take_nmi;
    logic take_ext;

    assign in_reset = !device_reset_n_in;
    assign off_mode = !test_reset_n_in && emulation_pin_zero && !emulation_pin_one_off;
    assign nmi_edge = !wdt_sel_ff && nmi_prev_ff && !nmi_watchdog_shared_pin_in;

    // Software clear of flags, written as one per bit
    always_comb
    begin
        flag_clear = 4'h0;
        if (reg_wr && reg_addr == `IRPC_OFS_FLAG_LO)
            flag_clear[1:0] = reg_wdata[1:0];
        if (reg_wr && reg_addr == `IRPC_OFS_FLAG_HI)
            flag_clear[3:2] = reg_wdata[1:0];
        flag_clear = flag_clear | svc_clear;
    end

    irpc_flag_bank u_flags
    (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .irq_n_in(ext_irq_n_in),
        .clear(flag_clear),
        .clear_all(in_reset),
        .flags(flags)
    );

    // Selection of the interrupt to service
    always_comb
    begin
        ready = flags & enable_ff & {4{!global_irq_mask_bit_ff}};
        svc_any = |ready;
        svc_idx = 2'd0;
        for (int k = `IRPC_NUM_EXT - 1; k >= 0; k--)
        begin
            if (ready[k])
                svc_idx = 2'(k);
        end
        take_nmi = state_ff == IRPC_ST_RUN && !in_reset && nmi_pend_ff;
        take_ext = state_ff == IRPC_ST_RUN && !in_reset && !nmi_pend_ff && svc_any;
        svc_clear = 4'h0;
        if (take_ext)
            svc_clear[svc_idx] = 1'b1;
    end

    // Register next values
    always_comb
    begin
        nxt_enable = enable_ff;
        nxt_global_irq_mask_bit = global_irq_mask_bit_ff;
        nxt_wdt_sel = wdt_sel_ff;
        nxt_vecptr = vecptr_ff;
        nxt_host_irq = host_irq_ff;
        nxt_rdata = '0;
        if (in_reset)
        begin
            nxt_enable = `IRPC_RST_ENABLE;
            nxt_global_irq_mask_bit = `IRPC_RST_GLOBAL_MASK;
            nxt_wdt_sel = `IRPC_RST_WDT_SEL;
            nxt_vecptr = `IRPC_RST_VECPTR;
            nxt_host_irq = `IRPC_RST_HOST_IRQ;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                `IRPC_OFS_ENABLE_LO: nxt_enable[1:0] = reg_wdata[1:0];
                `IRPC_OFS_ENABLE_HI: nxt_enable[3:2] = reg_wdata[1:0];
                `IRPC_OFS_STATUS_ONE:
                    nxt_global_irq_mask_bit = reg_wdata[`IRPC_BIT_GLOBAL_MASK];
                `IRPC_OFS_TIMER_SEL: nxt_wdt_sel = reg_wdata[`IRPC_BIT_WDT_SEL];
                `IRPC_OFS_VECPTR: nxt_vecptr = reg_wdata[15:0];
                `IRPC_OFS_HOST_CTRL: nxt_host_irq = reg_wdata[`IRPC_BIT_HOST_IRQ];
                default: nxt_global_irq_mask_bit = global_irq_mask_bit_ff;
            endcase
        end
        // Servicing an interrupt masks further maskable ones
        if (take_nmi || take_ext)
            nxt_global_irq_mask_bit = 1'b1;
        if (reg_rd)
        begin
            unique case (reg_addr)
                `IRPC_OFS_ENABLE_LO: nxt_rdata[1:0] = enable_ff[1:0];
                `IRPC_OFS_ENABLE_HI: nxt_rdata[1:0] = enable_ff[3:2];
                `IRPC_OFS_FLAG_LO: nxt_rdata[1:0] = flags[1:0];
                `IRPC_OFS_FLAG_HI: nxt_rdata[1:0] = flags[3:2];
                `IRPC_OFS_STATUS_ONE: nxt_rdata[`IRPC_BIT_GLOBAL_MASK] = global_irq_mask_bit_ff;
                `IRPC_OFS_TIMER_SEL: nxt_rdata[`IRPC_BIT_WDT_SEL] = wdt_sel_ff;
                `IRPC_OFS_VECPTR: nxt_rdata[15:0] = vecptr_ff;
                `IRPC_OFS_HOST_CTRL: nxt_rdata[`IRPC_BIT_HOST_IRQ] = host_irq_ff;
                `IRPC_OFS_STATE:
                begin
                    nxt_rdata[`IRPC_BIT_ST_RUN] = state_ff != IRPC_ST_HOLD;
                    nxt_rdata[`IRPC_BIT_ST_NMI] = nmi_pend_ff;
                    nxt_rdata[`IRPC_BIT_ST_OFF] = off_mode;
                    nxt_rdata[`IRPC_BIT_ST_HPE] = host_port_enable_in;
                end
                default: nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            enable_ff <= `IRPC_RST_ENABLE;
            global_irq_mask_bit_ff <= `IRPC_RST_GLOBAL_MASK;
            wdt_sel_ff <= `IRPC_RST_WDT_SEL;
            vecptr_ff <= `IRPC_RST_VECPTR;
            host_irq_ff <= `IRPC_RST_HOST_IRQ;
            rdata_ff <= '0;
        end
        else
        begin
            enable_ff <= nxt_enable;
            global_irq_mask_bit_ff <= nxt_global_irq_mask_bit;
            wdt_sel_ff <= nxt_wdt_sel;
            vecptr_ff <= nxt_vecptr;
            host_irq_ff <= nxt_host_irq;
            rdata_ff <= nxt_rdata;
        end
    end

    // Reset and vector fetch sequencer
    always_comb
    begin
        nxt_state = state_ff;
        nxt_nmi_prev = nmi_watchdog_shared_pin_in;
        nxt_nmi_pend = nmi_pend_ff;
        nxt_fetch = 1'b0;
        nxt_vaddr = vaddr_ff;
        if (take_nmi)
            nxt_nmi_pend = 1'b0;
        if (nmi_edge)
            nxt_nmi_pend = 1'b1;
        if (in_reset)
        begin
            nxt_state = IRPC_ST_HOLD;
            nxt_nmi_pend = 1'b0;
        end
        else
        begin
            unique case (state_ff)
                IRPC_ST_HOLD:
                begin
                    nxt_state = IRPC_ST_BOOT;
                    nxt_fetch = 1'b1;
                    nxt_vaddr = {vecptr_ff, `IRPC_VEC_RESET};
                end
                IRPC_ST_BOOT: nxt_state = IRPC_ST_RUN;
                IRPC_ST_RUN:
                begin
                    if (take_nmi || take_ext)
                    begin
                        nxt_state = IRPC_ST_ACK;
                        nxt_fetch = 1'b1;
                        if (take_nmi)
                            nxt_vaddr = {vecptr_ff, `IRPC_VEC_NMI};
                        else
                            nxt_vaddr = {vecptr_ff, 8'(`IRPC_VEC_INT_BASE + {svc_idx, 3'b000})};
                    end
                end
                IRPC_ST_ACK: nxt_state = IRPC_ST_RUN;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            state_ff <= IRPC_ST_HOLD;
            nmi_prev_ff <= 1'b1;
            nmi_pend_ff <= 1'b0;
            fetch_ff <= 1'b0;
            vaddr_ff <= 24'h000000;
        end
        else
        begin
            state_ff <= nxt_state;
            nmi_prev_ff <= nxt_nmi_prev;
            nmi_pend_ff <= nxt_nmi_pend;
            fetch_ff <= nxt_fetch;
            vaddr_ff <= nxt_vaddr;
        end
    end

    // Pin drivers
    always_comb
    begin
        nxt_wdt_pin = watchdog_out;
        nxt_wdt_oe_n = !(wdt_sel_ff && !in_reset && !off_mode);
        nxt_ack = !(nxt_state == IRPC_ST_ACK);
        if (in_reset)
            nxt_ack = 1'b1;
        nxt_ack_oe_n = off_mode;
        nxt_hpe = host_port_enable_in && !in_reset && !off_mode;
        nxt_host_irq_out = !host_irq_ff;
        nxt_host_irq_out_oe_n = !nxt_hpe;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            wdt_pin_ff <= 1'b1;
            wdt_oe_n_ff <= 1'b1;
            ack_ff <= 1'b1;
            ack_oe_n_ff <= 1'b0;
            host_irq_out_ff <= 1'b1;
            host_irq_out_oe_n_ff <= 1'b1;
            hpe_ff <= 1'b0;
        end
        else
        begin
            wdt_pin_ff <= nxt_wdt_pin;
            wdt_oe_n_ff <= nxt_wdt_oe_n;
            ack_ff <= nxt_ack;
            ack_oe_n_ff <= nxt_ack_oe_n;
            host_irq_out_ff <= nxt_host_irq_out;
            host_irq_out_oe_n_ff <= nxt_host_irq_out_oe_n;
            hpe_ff <= nxt_hpe;
        end
    end

    assign reg_rdata = rdata_ff;
    assign nmi_watchdog_shared_pin_out = wdt_pin_ff;
    assign nmi_watchdog_shared_pin_oe_n = wdt_oe_n_ff;
    assign watchdog_pin_to_timer = nmi_watchdog_shared_pin_in && wdt_sel_ff;
    assign irq_acknowledge_out = ack_ff;
    assign irq_acknowledge_oe_n = ack_oe_n_ff;
    assign host_irq_out = host_irq_out_ff;
    assign host_irq_oe_n = host_irq_out_oe_n_ff;
    assign host_port_active = hpe_ff;
    assign exec_run = state_ff != IRPC_ST_HOLD;
    assign vector_fetch = fetch_ff;
    assign vector_addr = vaddr_ff;
    assign cpu_irq_out = svc_any || nmi_pend_ff;

endmodule : irpc_top
`default_nettype wire

// File: sim/irpc_monitor.sv
/*
 * Concurrent checks on the pins of the interrupt and reset pin control top.
 * Assumes binding into irpc_top, one clock sys_clk, synchronous active-high sys_rst.
 */
`timescale 1ns/1ns
`default_nettype none
`include "irpc_cfg.svh"

module irpc_monitor
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic reg_rd,
    input wire logic [`IRPC_DATA_W-1:0] reg_rdata,
    input wire logic device_reset_n_in,
    input wire logic watchdog_out,
    input wire logic nmi_watchdog_shared_pin_out,
    input wire logic nmi_watchdog_shared_pin_oe_n,
    input wire logic irq_acknowledge_out,
    input wire logic irq_acknowledge_oe_n,
    input wire logic host_irq_oe_n,
    input wire logic host_port_enable_in,
    input wire logic host_port_active,
    input wire logic test_reset_n_in,
    input wire logic emulation_pin_zero,
    input wire logic emulation_pin_one_off,
    input wire logic exec_run,
    input wire logic vector_fetch,
    input wire logic [23:0] vector_addr
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    logic off_mode;
    assign off_mode = !test_reset_n_in && emulation_pin_zero && !emulation_pin_one_off;

    chk_ack_in_reset: assert property (
        !$past(device_reset_n_in) |-> irq_acknowledge_out && !exec_run)
        else $error("acknowledge or run wrong in reset");
    chk_host_hiz_rst: assert property (
        !$past(device_reset_n_in) |-> host_irq_oe_n)
        else $error("host interrupt driven in reset");
    chk_host_port_off: assert property (
        !$past(host_port_enable_in) |-> host_irq_oe_n && !host_port_active)
        else $error("host port active while disabled");
    chk_off_mode_hiz: assert property (
        $past(off_mode) |-> irq_acknowledge_oe_n && host_irq_oe_n && nmi_watchdog_shared_pin_oe_n)
        else $error("pin driven in off mode");
    chk_boot_vector: assert property (
        $rose(device_reset_n_in) |=>
        vector_fetch && vector_addr == 24'hffff00 && irq_acknowledge_out)
        else $error("reset vector not fetched");
    chk_fetch_pulse: assert property (vector_fetch |=> !vector_fetch)
        else $error("vector fetch longer than a cycle");
    chk_ack_on_fetch: assert property (
        vector_fetch && vector_addr[7:0] != 8'h00 |-> !irq_acknowledge_out)
        else $error("no acknowledge on interrupt fetch");
    chk_ack_only_fetch: assert property (!irq_acknowledge_out |-> vector_fetch)
        else $error("acknowledge without fetch");
    chk_wdt_pin_copy: assert property (
        !nmi_watchdog_shared_pin_oe_n |-> nmi_watchdog_shared_pin_out == $past(watchdog_out))
        else $error("watchdog pin not following timer");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read slot");

    cover property (vector_fetch && vector_addr[7:0] == 8'h08);
    cover property (vector_fetch && vector_addr[7:0] == 8'h20);
    cover property (!nmi_watchdog_shared_pin_oe_n);
endmodule : irpc_monitor
`default_nettype wire

// File: sim/irpc_src_model.sv
/*
 * External interrupt sources: active-low lines that follow a request level.
 * Assumes the bench raises a request level for a few cycles per event.
 */
`timescale 1ns/1ns
`default_nettype none

module irpc_src_model
(
    input wire logic sys_clk,
    input wire irpc_pkg::irpc_src_type fire,
    input wire logic nmi_fire,
    output irpc_pkg::irpc_src_type irq_n,
    output logic nmi_n
);
    import irpc_pkg::*;
    // Falling edge per request, idle high
    always_ff @(posedge sys_clk)
    begin
        irq_n <= ~fire;
        nmi_n <= ~nmi_fire;
    end
endmodule : irpc_src_model
`default_nettype wire

// File: sim/tb_top.sv
/*
 * Self-checking bench for irpc_top with an interrupt source model.
 * Assumes 125 MHz sys_clk and the register map of irpc_cfg.svh.
 */
`timescale 1ns/1ns
`default_nettype none
`include "irpc_cfg.svh"

module tb_top;
    import irpc_pkg::*;
    logic sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, device_reset_n_in = 0;
    logic watchdog_out = 0, host_port_enable_in = 1, nmi_fire = 0, nmi_n;
    logic test_reset_n_in = 1, emulation_pin_zero = 0, emulation_pin_one_off = 1;
    logic [7:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, rv;
    irpc_src_type fire = 0, ext_irq_n_in;
    logic nmi_watchdog_shared_pin_in, nmi_watchdog_shared_pin_out, nmi_watchdog_shared_pin_oe_n;
    logic watchdog_pin_to_timer, irq_acknowledge_out, irq_acknowledge_oe_n, host_irq_out;
    logic host_irq_oe_n, host_port_active, exec_run, vector_fetch, cpu_irq_out;
    logic [23:0] vector_addr;
    int fails = 0, checks = 0;

    always #4 sys_clk = ~sys_clk;
    assign nmi_watchdog_shared_pin_in = nmi_watchdog_shared_pin_oe_n ? nmi_n
        : nmi_watchdog_shared_pin_out;
    irpc_top dut_u (.*);
    irpc_src_model src_u (.sys_clk(sys_clk), .fire(fire), .nmi_fire(nmi_fire),
        .irq_n(ext_irq_n_in), .nmi_n(nmi_n));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge sys_clk);
        reg_wr <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge sys_clk);
        reg_rd <= 0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic pulse(input irpc_src_type m, input logic n);
        @(posedge sys_clk);
        fire <= m;
        nmi_fire <= n;
        repeat (3) @(posedge sys_clk);
        fire <= 0;
        nmi_fire <= 0;
    endtask : pulse
    task automatic wait_fetch(input logic [23:0] va, input logic ack);
        int i;
        #1;
        for (i = 0; i < 40 && vector_fetch !== 1'b1; i++)
            @(posedge sys_clk) #1;
        chk("vector_fetch", vector_fetch, 1);
        chk("vector_addr", vector_addr, va);
        chk("acknowledge", irq_acknowledge_out, ack);
    endtask : wait_fetch
    task automatic t_boot;
        @(posedge sys_clk);
        device_reset_n_in <= 1;
        wait_fetch(24'hffff00, 1);
        chk("timer pin", watchdog_pin_to_timer, 0);
        rd(`IRPC_OFS_STATUS_ONE, rv);
        chk("global mask", rv, 1);
        rd(`IRPC_OFS_TIMER_SEL, rv);
        chk("timer select", rv, 0);
        rd(`IRPC_OFS_VECPTR, rv);
        chk("vecptr", rv, 32'hffff);
        rd(8'h40, rv);
        chk("unmapped", rv, 0);
        chk("host_irq_out", {host_irq_oe_n, host_irq_out}, 1);
    endtask : t_boot
    task automatic t_mask;
        wr(`IRPC_OFS_ENABLE_LO, 1);
        pulse(4'h1, 0);
        rd(`IRPC_OFS_FLAG_LO, rv);
        chk("flag0", rv, 1);
        chk("masked irq", cpu_irq_out, 0);
        wr(`IRPC_OFS_FLAG_LO, 1);
        rd(`IRPC_OFS_FLAG_LO, rv);
        chk("flag0 clr", rv, 0);
        pulse(4'h2, 0);
        wr(`IRPC_OFS_STATUS_ONE, 0);
        repeat (3) @(posedge sys_clk) #1;
        chk("disabled irq", {vector_fetch, cpu_irq_out}, 0);
        wr(`IRPC_OFS_FLAG_LO, 2);
    endtask : t_mask
    task automatic t_prio;
        wr(`IRPC_OFS_ENABLE_HI, 3);
        pulse(4'hc, 0);
        wait_fetch(24'hffff20, 0);
        rd(`IRPC_OFS_STATUS_ONE, rv);
        chk("mask set", rv, 1);
        wr(`IRPC_OFS_STATUS_ONE, 0);
        wait_fetch(24'hffff28, 0);
    endtask : t_prio
    task automatic t_nmi;
        pulse(4'h1, 1);
        wait_fetch(24'hffff08, 0);
        wr(`IRPC_OFS_STATUS_ONE, 0);
        #1 chk("irq level", cpu_irq_out, 1);
        wait_fetch(24'hffff10, 0);
    endtask : t_nmi
    task automatic t_pins;
        wr(`IRPC_OFS_TIMER_SEL, 1);
        watchdog_out <= 1;
        repeat (3) @(posedge sys_clk) #1;
        chk("wdt pin", {nmi_watchdog_shared_pin_oe_n, nmi_watchdog_shared_pin_out}, 1);
        chk("wdt to timer", watchdog_pin_to_timer, 1);
        wr(`IRPC_OFS_TIMER_SEL, 0);
        wr(`IRPC_OFS_HOST_CTRL, 1);
        repeat (2) @(posedge sys_clk) #1;
        chk("host irq low", {host_irq_oe_n, host_irq_out}, 0);
        @(posedge sys_clk);
        host_port_enable_in <= 0;
        repeat (2) @(posedge sys_clk) #1;
        chk("host port off", {host_irq_oe_n, host_port_active}, 2);
        @(posedge sys_clk);
        host_port_enable_in <= 1;
        test_reset_n_in <= 0;
        emulation_pin_zero <= 1;
        emulation_pin_one_off <= 0;
        repeat (3) @(posedge sys_clk) #1;
        chk("off", {irq_acknowledge_oe_n, host_irq_oe_n}, 3);
        rd(`IRPC_OFS_STATE, rv);
        chk("state reg", rv, 32'hd);
        @(posedge sys_clk);
        test_reset_n_in <= 1;
        emulation_pin_one_off <= 1;
        device_reset_n_in <= 0;
        repeat (3) @(posedge sys_clk) #1;
        chk("wdt hiz", nmi_watchdog_shared_pin_oe_n, 1);
        chk("in reset", {irq_acknowledge_out, exec_run, host_irq_oe_n}, 5);
        t_boot();
    endtask : t_pins
    task automatic end_of_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test

    initial
    begin
        repeat (16) @(posedge sys_clk);
        sys_rst <= 0;
        repeat (2) @(posedge sys_clk);
        t_boot();
        t_mask();
        t_prio();
        t_nmi();
        t_pins();
        end_of_test();
    end
    initial
    begin
        #20000;
        fails++;
        end_of_test();
    end
endmodule : tb_top

bind irpc_top irpc_monitor mon_u (.*);
`default_nettype wire
